// ===== hw/tcc_pkg.sv
// Shared constants and types for the three-channel timer
package tcc_pkg;

    // Counter geometry
    localparam int              TCC_CNT_W       = 16;
    localparam int              TCC_CH_NUM      = 3;
    localparam logic [15:0]     TCC_CNT_RESET   = 16'h0000;
    localparam logic [15:0]     TCC_CNT_MAX     = 16'hFFFF;

    // Clock source select codes
    localparam logic [1:0]      TCC_SRC_EXT     = 2'h0;
    localparam logic [1:0]      TCC_SRC_AUX     = 2'h1;
    localparam logic [1:0]      TCC_SRC_SUB     = 2'h2;
    localparam logic [1:0]      TCC_SRC_ALT     = 2'h3;

    // Capture input select codes
    localparam logic [1:0]      TCC_CIS_PIN     = 2'h0;
    localparam logic [1:0]      TCC_CIS_SECOND  = 2'h1;
    localparam logic [1:0]      TCC_CIS_SW_LOW  = 2'h2;
    localparam logic [1:0]      TCC_CIS_SW_HIGH = 2'h3;

    // Shared vector words, one per pending source
    localparam logic [15:0]     TCC_VEC_NONE    = 16'h0000;
    localparam logic [15:0]     TCC_VEC_CH1     = 16'h0002;
    localparam logic [15:0]     TCC_VEC_CH2     = 16'h0004;
    localparam logic [15:0]     TCC_VEC_OVF     = 16'h000A;

    // Interrupt vector addresses, priorities and dispatch cost
    localparam logic [15:0]     TCC_CH0_VEC_ADDR    = 16'hFFF2;
    localparam logic [15:0]     TCC_SHARED_VEC_ADDR = 16'hFFF0;
    localparam logic [3:0]      TCC_CH0_PRIO        = 4'h9;
    localparam logic [3:0]      TCC_SHARED_PRIO     = 4'h8;
    localparam int              TCC_DISPATCH_CYC    = 5;

    // Counting modes
    typedef enum logic [1:0] {
        TCC_MODE_STOP,
        TCC_MODE_UP,
        TCC_MODE_CONT,
        TCC_MODE_UPDOWN
    } tcc_mode_t;

    // Capture edge choice: none, rising, falling, both
    function automatic logic tcc_edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        tcc_edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
    endfunction

endpackage

// ===== hw/tcc_prescale.sv
`timescale 1ns/100ps
// Clock source selection and divide-by-1/2/4/8 prescaler
module tcc_prescale
    import tcc_pkg::*;
(
    // System
    input  wire logic           clk_in,
    input  wire logic           resetn_in,
    // Clock sources, sampled as levels
    input  wire logic           ext_timer_clock_pin_in,
    input  wire logic           aux_clock_in,
    input  wire logic           sub_main_clock_in,
    input  wire logic           alt_ext_clock_input_in,
    // Control
    input  wire logic [1:0]     src_sel_in,
    input  wire logic [1:0]     div_sel_in,
    input  wire logic           clear_in,
    // Count enable pulse
    output logic                tick_out
);

    logic       src_level;      // Selected source level
    logic       src_prev;       // Level one cycle earlier
    logic [2:0] div_cnt;        // Divider position
    logic       src_rise;       // Rising edge of the source

    // Source multiplexer
    always_comb begin
        case (src_sel_in)
            TCC_SRC_EXT: src_level = ext_timer_clock_pin_in;
            TCC_SRC_AUX: src_level = aux_clock_in;
            TCC_SRC_SUB: src_level = sub_main_clock_in;
            default:     src_level = alt_ext_clock_input_in;
        endcase
    end

    assign src_rise = tcc_edge_hit(2'h1, src_prev, src_level);

    // Edge history of the source
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            src_prev <= 1'b0;
        end else begin
            src_prev <= src_level;
        end
    end

    // Divider counts source edges, pulses on the last of each group
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_cnt  <= 3'h0;
            tick_out <= 1'b0;
        end else if (clear_in) begin
            div_cnt  <= 3'h0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (src_rise) begin // RL2
                if (div_cnt >= ((3'h1 << div_sel_in) - 3'h1)) begin // RL3
                    div_cnt  <= 3'h0;
                    tick_out <= 1'b1;
                end else begin
                    div_cnt <= div_cnt + 3'h1;
                end
            end
        end
    end

    // A divide-by-one setting passes every source edge
    div_one_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL3
        (src_rise && div_sel_in == 2'h0 && !clear_in) |=> tick_out)
        else $error("divide by one lost a source edge");

endmodule

// ===== hw/tcc_channel.sv
`timescale 1ns/100ps
// One capture/compare channel with its output unit
module tcc_channel
    import tcc_pkg::*;
(
    // System
    input  wire logic           clk_in,
    input  wire logic           resetn_in,
    // Counter view
    input  wire logic [15:0]    cnt_in,
    input  wire logic           cnt_moved_in,
    input  wire logic           period_hit_in,
    // Capture inputs
    input  wire logic           event_pin_in,
    input  wire logic           second_in,
    // Configuration
    input  wire logic           capture_en_in,
    input  wire logic [1:0]     cap_edge_in,
    input  wire logic [1:0]     capture_input_select_in,
    input  wire logic [2:0]     out_mode_in,
    input  wire logic           out_bit_in,
    input  wire logic           cmp_wr_in,
    input  wire logic [15:0]    cmp_wdata_in,
    // Results
    output logic [15:0]         cmp_value_out,
    output logic                event_out,
    output logic                out_pin_out
);

    logic   cap_level;  // Selected capture input
    logic   cap_prev;   // Its level one cycle earlier
    logic   cap_hit;    // Selected edge seen in capture operation
    logic   cmp_hit;    // Counter arrived at the compare value

    // Capture input select, software levels let a write make the edge
    always_comb begin
        case (capture_input_select_in)
            TCC_CIS_PIN:    cap_level = event_pin_in; // RL9
            TCC_CIS_SECOND: cap_level = second_in; // RL10
            TCC_CIS_SW_LOW: cap_level = 1'b0; // RL11
            default:        cap_level = 1'b1; // RL11
        endcase
    end

    assign cap_hit = capture_en_in && tcc_edge_hit(cap_edge_in, cap_prev, cap_level); // RL7 RL8
    assign cmp_hit = !capture_en_in && cnt_moved_in && (cnt_in == cmp_value_out); // RL6

    // Capture input history
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cap_prev <= 1'b0;
        end else begin
            cap_prev <= cap_level;
        end
    end

    // Compare value: software write, or latch of the counter on capture
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cmp_value_out <= TCC_CNT_RESET;
            event_out     <= 1'b0;
        end else begin
            event_out <= cap_hit | cmp_hit;
            if (cap_hit) begin
                cmp_value_out <= cnt_in; // RL7
            end else if (cmp_wr_in) begin
                cmp_value_out <= cmp_wdata_in;
            end
        end
    end

    // Output unit: bit mode runs free, others react to compare, modes 2, 3, 6, 7 also to period
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            out_pin_out <= 1'b0;
        end else if (out_mode_in == 3'h0) begin
            out_pin_out <= out_bit_in; // RL13
        end else if (cmp_hit) begin // RL12
            case (out_mode_in)
                3'h1, 3'h3: out_pin_out <= 1'b1;
                3'h5, 3'h7: out_pin_out <= 1'b0;
                default:    out_pin_out <= ~out_pin_out;
            endcase
        end else if (period_hit_in) begin // RL13
            case (out_mode_in)
                3'h2, 3'h3: out_pin_out <= 1'b0;
                3'h6, 3'h7: out_pin_out <= 1'b1;
                default:    out_pin_out <= out_pin_out;
            endcase
        end
    end

    // A capture holds the counter value from the edge cycle
    capture_latch_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL7
        cap_hit |=> (cmp_value_out == $past(cnt_in)) && event_out)
        else $error("capture did not latch the counter");

endmodule

// ===== hw/tcc_timer.sv
`timescale 1ns/100ps
// Operation
// RL1: Sixteen-bit counter with three capture/compare channels
// RL2: Source select picks one of four clocks
// RL3: Prescaler divides by one, two, four, eight
// RL4: Software halts, reads and writes the counter
// RL5: Modes stop, continuous, up, up/down
// RL6: Each channel independently capture or compare
// RL7: Capture on rising, falling or both edges
// RL8: Capture started and stopped by software
// RL9: Each channel has its own event pin
// RL10: Channel 2 second input is auxiliary clock
// RL11: Select codes 2 and 3 give software capture
// RL12: Each channel has its own output unit
// RL13: Output unit free-running or trigger driven
// RL14: Channel 0 vector, plus one shared vector
// RL15: Shared vector word names the pending source
// RL16: Equal five-cycle dispatch for shared sources
// RL17: Maskable vectors FFF2h prio 9, FFF0h prio 8
// RL18: Interrupt flags held inside the timer
// RL19: Up wraps at period, up/down reverses there
module tcc_timer
    import tcc_pkg::*;
#(
    parameter int CH_NUM = TCC_CH_NUM
)
(
    // System
    input  wire logic           clk_in,
    input  wire logic           resetn_in,
    // Clock sources
    input  wire logic           ext_timer_clock_pin_in,
    input  wire logic           aux_clock_in,
    input  wire logic           sub_main_clock_in,
    input  wire logic           alt_ext_clock_input_in,
    // Counter control
    input  wire logic [1:0]     src_sel_in,
    input  wire logic [1:0]     div_sel_in,
    input  wire logic [1:0]     mode_in,
    input  wire logic           cnt_clear_in,
    input  wire logic           cnt_wr_in,
    input  wire logic [15:0]    cnt_wdata_in,
    // Counter status
    output logic [15:0]         cnt_out,
    output logic                count_down_out,
    // Event pins
    input  wire logic           event_pin_ch0_in,
    input  wire logic           event_pin_ch1_in,
    input  wire logic           event_pin_ch2_in,
    // Channel configuration, one entry per channel
    input  wire logic           capture_en_in [CH_NUM],
    input  wire logic [1:0]     cap_edge_in [CH_NUM],
    input  wire logic [1:0]     capture_input_select_in [CH_NUM],
    input  wire logic [2:0]     out_mode_in [CH_NUM],
    input  wire logic           out_bit_in [CH_NUM],
    input  wire logic           cmp_wr_in [CH_NUM],
    input  wire logic [15:0]    cmp_wdata_in [CH_NUM],
    // Channel results
    output logic [15:0]         channel0_compare_value_out,
    output logic [15:0]         channel1_compare_value_out,
    output logic [15:0]         channel2_compare_value_out,
    output logic [2:0]          out_pin_out,
    // Interrupt enables and flag clears
    input  wire logic [2:0]     ch_irq_en_in,
    input  wire logic           ovf_irq_en_in,
    input  wire logic [2:0]     ch_flag_clr_in,
    input  wire logic           ovf_flag_clr_in,
    input  wire logic           vector_rd_in,
    // Interrupt status
    output logic                channel0_irq_flag_out,
    output logic                channel1_irq_flag_out,
    output logic                channel2_irq_flag_out,
    output logic                counter_overflow_flag_out,
    output logic [15:0]         vector_word_out,
    output logic                irq_ch0_out,
    output logic                irq_shared_out,
    output logic [15:0]         ch0_vec_addr_out,
    output logic [15:0]         shared_vec_addr_out,
    output logic [3:0]          ch0_prio_out,
    output logic [3:0]          shared_prio_out
);

    logic               tick;           // Prescaled count enable
    logic               step;           // Counter may advance
    logic               cnt_moved;      // Counter advanced last cycle
    logic               period_hit;     // Counter at channel 0 value after a move
    logic [15:0]        next_cnt;       // Counter value after a step
    logic               next_down;      // Direction after a step
    logic               wrap;           // Step produces an overflow
    logic [CH_NUM-1:0]  ch_event;       // Capture or compare event pulses
    logic [15:0]        cmp_val [CH_NUM];   // Compare values
    logic [CH_NUM-1:0]  pin_sel;        // Event pin per channel
    logic [CH_NUM-1:0]  second_sel;     // Second capture input per channel
    logic [15:0]        next_vector;    // Highest pending shared source
    logic [2:0]         vec_clr;        // Flag cleared by a vector read

    assign pin_sel    = {event_pin_ch2_in, event_pin_ch1_in, event_pin_ch0_in}; // RL9
    assign second_sel = {aux_clock_in, 1'b0, 1'b0}; // RL10
    assign step       = tick && (mode_in != TCC_MODE_STOP) && !cnt_wr_in; // RL4
    assign period_hit = cnt_moved && (cnt_out == cmp_val[0]);

    // Clock source and prescaler
    tcc_prescale u_prescale (
        .clk_in                 (clk_in),
        .resetn_in              (resetn_in),
        .ext_timer_clock_pin_in (ext_timer_clock_pin_in),
        .aux_clock_in           (aux_clock_in),
        .sub_main_clock_in      (sub_main_clock_in),
        .alt_ext_clock_input_in (alt_ext_clock_input_in),
        .src_sel_in             (src_sel_in),
        .div_sel_in             (div_sel_in),
        .clear_in               (cnt_clear_in),
        .tick_out               (tick)
    ); // RL2 RL3

    // Three independent channels
    for (genvar i = 0; i < CH_NUM; i++) begin : g_ch
        tcc_channel u_ch (
            .clk_in                  (clk_in),
            .resetn_in               (resetn_in),
            .cnt_in                  (cnt_out),
            .cnt_moved_in            (cnt_moved),
            .period_hit_in           (period_hit),
            .event_pin_in            (pin_sel[i]),
            .second_in               (second_sel[i]),
            .capture_en_in           (capture_en_in[i]),
            .cap_edge_in             (cap_edge_in[i]),
            .capture_input_select_in (capture_input_select_in[i]),
            .out_mode_in             (out_mode_in[i]),
            .out_bit_in              (out_bit_in[i]),
            .cmp_wr_in               (cmp_wr_in[i]),
            .cmp_wdata_in            (cmp_wdata_in[i]),
            .cmp_value_out           (cmp_val[i]),
            .event_out               (ch_event[i]),
            .out_pin_out             (out_pin_out[i])
        ); // RL1 RL6 RL12
    end

    assign channel0_compare_value_out = cmp_val[0];
    assign channel1_compare_value_out = cmp_val[1];
    assign channel2_compare_value_out = cmp_val[2];

    // Next counter value for each counting mode
    always_comb begin
        next_cnt  = cnt_out;
        next_down = count_down_out;
        wrap      = 1'b0;
        case (mode_in)
            TCC_MODE_UP: begin
                // Period set by channel 0 value
                if (cnt_out >= cmp_val[0]) begin // RL19
                    next_cnt = TCC_CNT_RESET;
                    wrap     = 1'b1;
                end else begin
                    next_cnt = cnt_out + 16'h0001;
                end
                next_down = 1'b0;
            end
            TCC_MODE_CONT: begin
                // Full sixteen-bit roll-over
                next_cnt  = cnt_out + 16'h0001;
                wrap      = (cnt_out == TCC_CNT_MAX);
                next_down = 1'b0;
            end
            TCC_MODE_UPDOWN: begin
                if (!count_down_out && cnt_out >= cmp_val[0]) begin // RL19
                    // Turn at the period value
                    next_down = 1'b1;
                    next_cnt  = (cnt_out == TCC_CNT_RESET) ? cnt_out : cnt_out - 16'h0001;
                end else if (count_down_out && cnt_out == TCC_CNT_RESET) begin
                    // Loaded at zero while falling, start rising again
                    next_down = 1'b0;
                    next_cnt  = cnt_out + 16'h0001;
                end else if (count_down_out) begin
                    next_cnt = cnt_out - 16'h0001;
                    if (cnt_out == 16'h0001) begin
                        // Bottom reached, overflow and turn
                        wrap      = 1'b1;
                        next_down = 1'b0;
                    end
                end else begin
                    next_cnt = cnt_out + 16'h0001;
                end
            end
            default: begin
                next_cnt = cnt_out;
            end
        endcase
    end

    // Counter register with software clear and write
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_out        <= TCC_CNT_RESET;
            count_down_out <= 1'b0;
            cnt_moved      <= 1'b0;
        end else begin
            cnt_moved <= step;
            if (cnt_clear_in) begin
                cnt_out        <= TCC_CNT_RESET;
                count_down_out <= 1'b0;
            end else if (cnt_wr_in) begin
                cnt_out <= cnt_wdata_in; // RL4
            end else if (step) begin // RL5
                cnt_out        <= next_cnt;
                count_down_out <= next_down;
            end
        end
    end

    // Highest pending enabled shared source
    always_comb begin
        next_vector = TCC_VEC_NONE;
        vec_clr     = 3'h0;
        if (channel1_irq_flag_out && ch_irq_en_in[1]) begin // RL15
            next_vector = TCC_VEC_CH1;
            vec_clr     = 3'h1;
        end else if (channel2_irq_flag_out && ch_irq_en_in[2]) begin
            next_vector = TCC_VEC_CH2;
            vec_clr     = 3'h2;
        end else if (counter_overflow_flag_out && ovf_irq_en_in) begin
            next_vector = TCC_VEC_OVF;
            vec_clr     = 3'h4;
        end
    end

    // Channel flags live here; a new event beats a clear in the same cycle
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            channel0_irq_flag_out <= 1'b0;
            channel1_irq_flag_out <= 1'b0;
            channel2_irq_flag_out <= 1'b0;
        end else begin // RL18
            channel0_irq_flag_out <= ch_event[0] | (channel0_irq_flag_out & ~ch_flag_clr_in[0]);
            channel1_irq_flag_out <= ch_event[1]
                | (channel1_irq_flag_out & ~ch_flag_clr_in[1] & ~(vector_rd_in & vec_clr[0]));
            channel2_irq_flag_out <= ch_event[2]
                | (channel2_irq_flag_out & ~ch_flag_clr_in[2] & ~(vector_rd_in & vec_clr[1]));
        end
    end

    // Overflow flag, set on each wrap of the counter
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            counter_overflow_flag_out <= 1'b0;
        end else begin // RL18
            counter_overflow_flag_out <= (step & wrap)
                | (counter_overflow_flag_out & ~ovf_flag_clr_in & ~(vector_rd_in & vec_clr[2]));
        end
    end

    // Vector word register, one value per source gives equal dispatch cost
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            vector_word_out <= TCC_VEC_NONE;
        end else begin
            vector_word_out <= next_vector; // RL15 RL16
        end
    end

    // Two maskable interrupt lines and their fixed vector data
    assign irq_ch0_out         = channel0_irq_flag_out & ch_irq_en_in[0]; // RL14 RL17
    assign irq_shared_out      = vector_word_out != TCC_VEC_NONE; // RL14 RL17
    assign ch0_vec_addr_out    = TCC_CH0_VEC_ADDR; // RL17
    assign shared_vec_addr_out = TCC_SHARED_VEC_ADDR; // RL17
    assign ch0_prio_out        = TCC_CH0_PRIO;
    assign shared_prio_out     = TCC_SHARED_PRIO;

    // Up mode returns to zero after the period value
    up_wrap_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL19
        (step && !cnt_clear_in && mode_in == TCC_MODE_UP && cnt_out >= cmp_val[0])
        |=> (cnt_out == 16'h0000) ##1 (counter_overflow_flag_out))
        else $error("up mode did not wrap at the period");

    // Continuous mode steps by one
    cont_step_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL5
        (step && !cnt_clear_in && mode_in == TCC_MODE_CONT) |=> cnt_out == $past(cnt_out) + 16'h0001)
        else $error("continuous mode did not step by one");

    // A halted counter holds its value
    halt_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL4
        (mode_in == TCC_MODE_STOP && !cnt_wr_in && !cnt_clear_in) |=> $stable(cnt_out))
        else $error("halted counter moved");

    // A software write loads the counter
    cnt_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL4
        (cnt_wr_in && !cnt_clear_in) |=> cnt_out == $past(cnt_wdata_in))
        else $error("counter write lost");

    // Up/down mode turns downward at the period value
    updown_turn_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL19
        (step && !cnt_clear_in && mode_in == TCC_MODE_UPDOWN && !count_down_out
         && cnt_out >= cmp_val[0] && cnt_out != 16'h0000) |=> count_down_out && cnt_out == $past(cnt_out) - 16'h0001)
        else $error("up/down mode did not turn at the period");

    // A channel 0 event leaves its flag set even under a clear
    flag_set_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL18
        ch_event[0] |=> channel0_irq_flag_out)
        else $error("channel 0 event lost");

    // Channel 0 line follows its flag and mask
    irq_ch0_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL14
        irq_ch0_out |-> channel0_irq_flag_out && ch_irq_en_in[0])
        else $error("channel 0 interrupt without cause");

    // Vector word names channel 1 only when it was pending and enabled
    vector_ch1_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL15
        (vector_word_out == TCC_VEC_CH1) |-> $past(channel1_irq_flag_out && ch_irq_en_in[1]))
        else $error("vector word names a source that was not pending");

endmodule

// ===== tb/tcc_pin_model.sv
`timescale 1ns/100ps
// Far side: bursts of rising edges on the timer clock pin, low when idle
module tcc_pin_model (
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       go_in,
    input  wire logic [7:0] n_in,
    output logic            pin_out,
    output logic            busy_out
);
    logic [7:0] left;  // Edges still owed
    logic [1:0] ph;    // Pin high in phases 2 and 3
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {left, ph, pin_out, busy_out} <= 12'h000;
        end else if (go_in) begin
            {left, ph, busy_out} <= {n_in, 3'h1};
        end else if (left != 8'h00) begin
            ph      <= ph + 2'h1;
            pin_out <= ph[1];
            left    <= left - {7'h00, &ph};
        end else begin
            {pin_out, busy_out} <= 2'h0;
        end
    end
endmodule

// ===== tb/tcc_timer_tb_top.sv
`timescale 1ns/100ps
module tcc_timer_tb_top;
    logic        clk_in = 1'b0, rst_n = 1'b0, go = 1'b0, wr = 1'b0, clr = 1'b0, oen = 1'b0, oclr = 1'b0, vrd = 1'b0;
    logic [1:0]  ssel = 2'h0, dsel = 2'h0, mode = 2'h0;
    logic [2:0]  cen = 3'h0, cclr = 3'h0;
    logic [7:0]  ne = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic        cap [3] = '{3{1'b0}}, ob [3] = '{3{1'b0}}, cmw [3] = '{3{1'b0}};
    logic [1:0]  es [3] = '{3{2'h0}}, cis [3] = '{3{2'h0}};
    logic [2:0]  om [3] = '{3{3'h0}};
    logic [15:0] cmd [3] = '{3{16'h0000}};
    logic        pin, busy, f0, fo;
    logic [2:0]  op;
    logic [15:0] cnt, cv1, vec, va0, va1;
    logic [3:0]  pr0, pr1;
    int          failures = 0, n_compared = 0;
    tcc_timer i_tcc_timer (.clk_in(clk_in), .resetn_in(rst_n), .ext_timer_clock_pin_in(pin), .aux_clock_in(1'b0),
        .sub_main_clock_in(1'b0), .alt_ext_clock_input_in(1'b0), .src_sel_in(ssel), .div_sel_in(dsel),
        .mode_in(mode), .cnt_clear_in(clr), .cnt_wr_in(wr), .cnt_wdata_in(wd), .cnt_out(cnt), .count_down_out(),
        .event_pin_ch0_in(pin), .event_pin_ch1_in(1'b0), .event_pin_ch2_in(1'b0), .capture_en_in(cap),
        .cap_edge_in(es), .capture_input_select_in(cis), .out_mode_in(om), .out_bit_in(ob), .cmp_wr_in(cmw),
        .cmp_wdata_in(cmd), .channel0_compare_value_out(), .channel1_compare_value_out(cv1),
        .channel2_compare_value_out(), .out_pin_out(op), .ch_irq_en_in(cen), .ovf_irq_en_in(oen),
        .ch_flag_clr_in(cclr), .ovf_flag_clr_in(oclr), .vector_rd_in(vrd), .channel0_irq_flag_out(f0),
        .channel1_irq_flag_out(), .channel2_irq_flag_out(), .counter_overflow_flag_out(fo),
        .vector_word_out(vec), .irq_ch0_out(), .irq_shared_out(), .ch0_vec_addr_out(va0),
        .shared_vec_addr_out(va1), .ch0_prio_out(pr0), .shared_prio_out(pr1));
    tcc_pin_model i_tcc_pin_model (.clk_in(clk_in), .resetn_in(rst_n), .go_in(go), .n_in(ne),
        .pin_out(pin), .busy_out(busy));
    always #25 clk_in = ~clk_in;
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Burst of source edges, then let prescaler and counter settle
    task automatic burst(input logic [7:0] n);
        @(posedge clk_in) {go, ne} <= {1'b1, n};
        @(posedge clk_in) go <= 1'b0;
        @(negedge clk_in);
        for (int k = 0; busy && k < 200; k++) @(negedge clk_in);
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    task automatic results;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        results();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_in);
        rst_n <= 1'b1;
        @(negedge clk_in);
        chk({pr0, pr1, va0[3:0], va1[3:0]}, 16'h9820);
        @(posedge clk_in) mode <= 2'h2;
        burst(8'h05);
        chk(cnt, 16'h0005);
        @(posedge clk_in) {dsel, clr} <= 3'h3;
        @(posedge clk_in) clr <= 1'b0;
        burst(8'h08);
        chk(cnt, 16'h0004);
        @(posedge clk_in) {mode, dsel, wr, wd} <= {4'h0, 1'b1, 16'hFFFE};
        @(posedge clk_in) wr <= 1'b0;
        burst(8'h04);
        chk(cnt, 16'hFFFE);
        @(posedge clk_in) {mode, oen} <= 3'h5;
        burst(8'h03);
        chk(cnt, 16'h0001);
        chk(vec, 16'h000A);
        @(posedge clk_in) {mode, clr, oclr, cmw[0], cmd[0]} <= {2'h1, 3'h7, 16'h0002};
        @(posedge clk_in) {clr, oclr, cmw[0]} <= 3'h0;
        burst(8'h03);
        chk(cnt, 16'h0000);
        chk({14'h0000, fo, f0}, 16'h0003);
        @(posedge clk_in) {mode, oen, cen, cap[1], es[1], cis[1], wr, wd} <= {11'h056, 1'b1, 16'h1234};
        @(posedge clk_in) {wr, cclr} <= 4'h2;
        @(posedge clk_in) {cclr, cis[1]} <= 5'h03;
        repeat (5) @(posedge clk_in);
        @(negedge clk_in);
        chk(cv1, 16'h1234);
        chk(vec, 16'h0002);
        @(posedge clk_in) vrd <= 1'b1;
        @(posedge clk_in) vrd <= 1'b0;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        chk(vec, 16'h0000);
        // Up/down to period 2 with channel 0 output toggling on compare
        @(posedge clk_in) {mode, clr, oclr, om[0]} <= {2'h3, 2'h3, 3'h4};
        @(posedge clk_in) {clr, oclr} <= 2'h0;
        burst(8'h05);
        chk(cnt, 16'h0001);
        chk({12'h000, fo, op}, 16'h0009);
        results();
    end
endmodule
